// File: core/nibble_core.sv
// Instruction decode and execute core of a 4-bit controller.
// Assumes ROM and RAM read asynchronously from the registered addresses.
`timescale 1ns/1ns
module nibble_core (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Program ROM.
	input wire logic [7:0] rom_data_i,
	output logic [11:0] rom_addr_o,
	// Data RAM.
	input wire logic [3:0] ram_rdata_i,
	output logic [5:0] ram_raddr_o,
	output logic [5:0] ram_waddr_o,
	output logic [3:0] ram_wdata_o,
	output logic ram_we_o,
	// Pins and status sources.
	input wire logic [3:0] s_in_i,
	input wire logic [3:0] m_in_i,
	input wire logic tenth_sec_i,
	input wire logic [3:0] scan_flag_set_i,
	input wire logic [3:0] aux_status_i,
	input wire logic [3:0] sfr_rdata_i,
	// Function register port.
	output logic sfr_we_o,
	output logic [3:0] sfr_sel_o,
	output logic [3:0] sfr_wdata_o,
	// Control state.
	output logic [3:0] aux_ctrl_o,
	output logic [1:0] pulldown_flags_o,
	output logic [3:0] halt_release_ctrl_o,
	output logic divider_overflow_release_en_o,
	output logic chrono_run_flag_o,
	output logic strobe_ptr_ctrl_bit_o,
	output logic halt_o,
	output logic op_error_o,
	output logic [14:0] divider_o,
	output logic [nibble_pkg::WDT_W-1:0] watchdog_counter_o,
	output logic [3:0] acc_o,
	output logic carry_o
);
	nibble_pkg::state_t state_ff, nxt_state;
	logic [11:0] pc_ff, nxt_pc, rom_addr_ff, nxt_rom_addr, stk0_ff, nxt_stk0, stk1_ff, nxt_stk1;
	logic [11:0] jmp_target;
	logic [7:0] opc_ff, nxt_opc;
	logic [3:0] acc_ff, nxt_acc, dpl_ff, nxt_dpl, dph_ff, nxt_dph, svl_ff, nxt_svl;
	logic [3:0] svh_ff, nxt_svh, sp_ff, nxt_sp, hcs_ff, nxt_hcs, hrc_ff, nxt_hrc;
	logic [3:0] aux_ff, nxt_aux, wdata_ff, nxt_wdata, sfrd_ff, nxt_sfrd;
	logic [3:0] s_prev_ff, m_prev_ff;
	logic [2:0] page_ff, nxt_page;
	logic [1:0] pdf_ff, nxt_pdf;
	logic [5:0] waddr_ff, nxt_waddr;
	logic cf_ff, nxt_cf, hep_ff, nxt_hep, cst_ff, nxt_cst, spc_ff, nxt_spc;
	logic we_ff, nxt_we, sfrw_ff, nxt_sfrw, err_ff, nxt_err;
	logic two_byte, br_cond, release_now, div_clr, wdt_clr;
	logic [3:0] mem_rd;
	logic halt_ff;
	logic [14:0] div_ff, nxt_div;
	logic ovf_ff, nxt_ovf;
	logic [nibble_pkg::WDT_W-1:0] wdt_ff, nxt_wdt;

	// Prefix check, branch condition and halt release sources.
	assign two_byte = (rom_data_i[7:3] == nibble_pkg::PFX_JMP)
		| (rom_data_i[7:6] == nibble_pkg::PFX_BR)
		| (rom_data_i[7:3] == nibble_pkg::PFX_CALL)
		| (rom_data_i[7:3] == nibble_pkg::PFX_ALUI)
		| (rom_data_i == nibble_pkg::OP_BANK)
		| (rom_data_i == nibble_pkg::OP_SPCX);
	assign jmp_target = {pc_ff[11], opc_ff[2:0], rom_data_i};
	assign br_cond = opc_ff[3] ? acc_ff[opc_ff[5:4]]
		: (opc_ff[5:4] == 2'h0) ? (acc_ff == 4'h0)
		: (opc_ff[5:4] == 2'h1) ? (acc_ff != 4'h0)
		: (opc_ff[5:4] == 2'h2) ? !cf_ff : cf_ff;
	assign release_now = (hrc_ff[0] & hep_ff & ovf_ff)
		| (hrc_ff[1] & |(s_in_i & ~s_prev_ff))
		| (hrc_ff[2] & |(m_in_i & ~m_prev_ff))
		| (hrc_ff[3] & tenth_sec_i);

	// A store still in flight is forwarded, so a read right after it sees the new nibble.
	assign mem_rd = (we_ff && waddr_ff == {dph_ff[1:0], dpl_ff}) ? wdata_ff : ram_rdata_i;

	// Decode and execute next values.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_pc = pc_ff;
		nxt_opc = opc_ff;
		nxt_acc = acc_ff;
		nxt_cf = cf_ff;
		nxt_dpl = dpl_ff;
		nxt_dph = dph_ff;
		nxt_svl = svl_ff;
		nxt_svh = svh_ff;
		nxt_sp = sp_ff;
		nxt_hcs = hcs_ff;
		nxt_hrc = hrc_ff;
		nxt_aux = aux_ff;
		nxt_page = page_ff;
		nxt_pdf = pdf_ff;
		nxt_hep = hep_ff;
		nxt_cst = cst_ff;
		nxt_spc = spc_ff;
		nxt_stk0 = stk0_ff;
		nxt_stk1 = stk1_ff;
		nxt_we = 1'b0;
		nxt_wdata = wdata_ff;
		nxt_waddr = waddr_ff;
		nxt_sfrw = 1'b0;
		nxt_sfrd = sfrd_ff;
		nxt_err = 1'b0;
		div_clr = 1'b0;
		wdt_clr = 1'b0;
		unique case (state_ff)
			nibble_pkg::ST_FETCH:
			begin
				nxt_pc = pc_ff + 12'h001;
				if (two_byte)
				begin
					nxt_opc = rom_data_i;
					nxt_state = nibble_pkg::ST_OPER;
				end
				else
				begin
					casez (rom_data_i)
						nibble_pkg::OP_HALT: nxt_state = nibble_pkg::ST_HALT;
						nibble_pkg::OP_OP_ROM_NIBBLE_WRITE: nxt_state = nibble_pkg::ST_OP_ROM_NIBBLE_WRITE;
						nibble_pkg::OP_CSP: nxt_cst = 1'b0;
						nibble_pkg::OP_CST: nxt_cst = 1'b1;
						nibble_pkg::OP_RCS: nxt_hep = 1'b0;
						nibble_pkg::OP_SCS: nxt_hep = 1'b1;
						nibble_pkg::OP_JMPI: nxt_pc = {pc_ff[11], page_ff, acc_ff, mem_rd};
						nibble_pkg::OP_PAGE: nxt_page = mem_rd[2:0];
						nibble_pkg::OP_RTS:
						begin
							nxt_pc = stk0_ff;
							nxt_stk0 = stk1_ff;
						end
						nibble_pkg::OP_IN:
						begin
							if (spc_ff)
								nxt_acc = sfr_rdata_i;
							else if (sp_ff == nibble_pkg::SP_AUX)
								nxt_acc = aux_status_i;
							else
								nxt_err = 1'b1;
						end
						nibble_pkg::OP_OP_SET_PTR_LOW: nxt_dpl = acc_ff;
						nibble_pkg::OP_SDPH: nxt_dph = acc_ff;
						nibble_pkg::OP_XDPL:
						begin
							nxt_dpl = svl_ff;
							nxt_svl = dpl_ff;
						end
						nibble_pkg::OP_XDPH:
						begin
							nxt_dph = svh_ff;
							nxt_svh = dph_ff;
						end
						nibble_pkg::OP_IDPL: nxt_dpl = dpl_ff + 4'h1;
						nibble_pkg::OP_DDPL: nxt_dpl = dpl_ff - 4'h1;
						nibble_pkg::OP_IDPH: nxt_dph = dph_ff + 4'h1;
						nibble_pkg::OP_DDPH: nxt_dph = dph_ff - 4'h1;
						nibble_pkg::OP_ISP: nxt_sp = sp_ff + 4'h1;
						nibble_pkg::OP_DSP: nxt_sp = sp_ff - 4'h1;
						nibble_pkg::OP_IPM: nxt_acc = m_in_i;
						nibble_pkg::OP_IPS: nxt_acc = s_in_i;
						nibble_pkg::OP_LDA: nxt_acc = mem_rd;
						nibble_pkg::OP_LSP: nxt_acc = sp_ff;
						nibble_pkg::OP_SSP: nxt_sp = acc_ff;
						nibble_pkg::OP_OP_READ_CLEAR_HALT_STATUS:
						begin
							nxt_acc = hcs_ff;
							nxt_hcs = 4'h0;
						end
						nibble_pkg::OP_STA:
						begin
							nxt_we = 1'b1;
							nxt_wdata = acc_ff;
						end
						nibble_pkg::OP_RCF: nxt_cf = 1'b0;
						nibble_pkg::OP_SCF: nxt_cf = 1'b1;
						nibble_pkg::OP_OP_RESTART_WATCHDOG: wdt_clr = 1'b1;
						nibble_pkg::OP_OP_CLEAR_DIVIDER_TOP: div_clr = 1'b1;
						nibble_pkg::OP_OUT:
						begin
							if (spc_ff)
							begin
								nxt_sfrw = 1'b1;
								nxt_sfrd = acc_ff;
							end
							else if (sp_ff == nibble_pkg::SP_AUX)
								nxt_aux = acc_ff;
							else
								nxt_err = 1'b1;
						end
						nibble_pkg::OP_LDPL: nxt_acc = dpl_ff;
						nibble_pkg::OP_LDPH: nxt_acc = dph_ff;
						nibble_pkg::OP_MVI:
						begin
							nxt_we = 1'b1;
							nxt_wdata = rom_data_i[3:0];
						end
						nibble_pkg::OP_LDI: nxt_acc = rom_data_i[3:0];
						nibble_pkg::OP_MDPL: nxt_dpl = rom_data_i[3:0];
						nibble_pkg::OP_MDPH: nxt_dph = rom_data_i[3:0];
						nibble_pkg::OP_SIC: nxt_hrc = rom_data_i[3:0];
						nibble_pkg::OP_MSP: nxt_sp = rom_data_i[3:0];
						default:
						begin
							if (rom_data_i[7:2] == nibble_pkg::PDN_HI)
								nxt_pdf = rom_data_i[1:0];
						end
					endcase
				end
				nxt_waddr = {dph_ff[1:0], dpl_ff};
			end
			nibble_pkg::ST_OPER:
			begin
				nxt_pc = pc_ff + 12'h001;
				nxt_state = nibble_pkg::ST_FETCH;
				if (opc_ff[7:3] == nibble_pkg::PFX_JMP)
					nxt_pc = jmp_target;
				else if (opc_ff[7:6] == nibble_pkg::PFX_BR)
				begin
					if (br_cond)
						nxt_pc = jmp_target;
				end
				else if (opc_ff[7:3] == nibble_pkg::PFX_CALL)
				begin
					nxt_stk0 = pc_ff + 12'h001;
					nxt_stk1 = stk0_ff;
					nxt_pc = jmp_target;
				end
				else if (rom_data_i[7:1] == nibble_pkg::SEL_HI)
				begin
					if (opc_ff == nibble_pkg::OP_BANK)
						nxt_pc[11] = rom_data_i[0];
					else if (opc_ff == nibble_pkg::OP_SPCX)
						nxt_spc = rom_data_i[0];
				end
			end
			nibble_pkg::ST_OP_ROM_NIBBLE_WRITE:
			begin
				nxt_state = nibble_pkg::ST_FETCH;
				if (spc_ff)
				begin
					nxt_sfrw = 1'b1;
					nxt_sfrd = rom_data_i[7:4];
				end
				else if (sp_ff == nibble_pkg::SP_AUX)
					nxt_aux = rom_data_i[7:4];
				else
					nxt_err = 1'b1;
			end
			nibble_pkg::ST_HALT:
			begin
				if (release_now)
					nxt_state = nibble_pkg::ST_FETCH;
			end
		endcase
		// Hardware scan events win over the read-and-clear.
		nxt_hcs = nxt_hcs | scan_flag_set_i;
		if (nxt_state == nibble_pkg::ST_OP_ROM_NIBBLE_WRITE)
			nxt_rom_addr = {pc_ff[11:8], acc_ff, mem_rd};
		else
			nxt_rom_addr = nxt_pc;
	end

	// Registers of the decode and execute group.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_ff <= nibble_pkg::ST_FETCH;
			halt_ff <= 1'b0;
			pc_ff <= 12'h000;
			rom_addr_ff <= 12'h000;
			stk0_ff <= 12'h000;
			stk1_ff <= 12'h000;
			opc_ff <= 8'h00;
			{acc_ff, dpl_ff, dph_ff, svl_ff, svh_ff, sp_ff} <= 24'h000000;
			{hcs_ff, hrc_ff, aux_ff, wdata_ff, sfrd_ff} <= 20'h00000;
			{s_prev_ff, m_prev_ff} <= 8'h00;
			page_ff <= 3'h0;
			pdf_ff <= 2'h0;
			waddr_ff <= 6'h00;
			{cf_ff, hep_ff, cst_ff, spc_ff, we_ff, sfrw_ff, err_ff} <= 7'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			halt_ff <= (nxt_state == nibble_pkg::ST_HALT);
			pc_ff <= nxt_pc;
			rom_addr_ff <= nxt_rom_addr;
			stk0_ff <= nxt_stk0;
			stk1_ff <= nxt_stk1;
			opc_ff <= nxt_opc;
			{acc_ff, dpl_ff, dph_ff, svl_ff, svh_ff, sp_ff} <=
				{nxt_acc, nxt_dpl, nxt_dph, nxt_svl, nxt_svh, nxt_sp};
			{hcs_ff, hrc_ff, aux_ff, wdata_ff, sfrd_ff} <=
				{nxt_hcs, nxt_hrc, nxt_aux, nxt_wdata, nxt_sfrd};
			{s_prev_ff, m_prev_ff} <= {s_in_i, m_in_i};
			page_ff <= nxt_page;
			pdf_ff <= nxt_pdf;
			waddr_ff <= nxt_waddr;
			{cf_ff, hep_ff, cst_ff, spc_ff, we_ff, sfrw_ff, err_ff} <=
				{nxt_cf, nxt_hep, nxt_cst, nxt_spc, nxt_we, nxt_sfrw, nxt_err};
		end
	end

	// Divider stepping, top-stage clear, overflow pulse and watchdog.
	always_comb
	begin
		nxt_div = div_ff + 15'h0001;
		nxt_ovf = &div_ff;
		if (div_clr)
		begin
			nxt_div = div_ff & ~nibble_pkg::DIV_TOP_MASK;
			nxt_ovf = 1'b0;
		end
		nxt_wdt = wdt_ff;
		if (wdt_clr)
			nxt_wdt = '0;
		else if (ovf_ff)
			nxt_wdt = wdt_ff + {{(nibble_pkg::WDT_W-1){1'b0}}, 1'b1};
	end

	// Registers of the divider group.
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			div_ff <= 15'h0000;
			ovf_ff <= 1'b0;
			wdt_ff <= '0;
		end
		else
		begin
			div_ff <= nxt_div;
			ovf_ff <= nxt_ovf;
			wdt_ff <= nxt_wdt;
		end
	end

	// Outputs straight from registers.
	assign rom_addr_o = rom_addr_ff;
	assign ram_raddr_o = {dph_ff[1:0], dpl_ff};
	assign ram_waddr_o = waddr_ff;
	assign ram_wdata_o = wdata_ff;
	assign ram_we_o = we_ff;
	assign sfr_we_o = sfrw_ff;
	assign sfr_sel_o = sp_ff;
	assign sfr_wdata_o = sfrd_ff;
	assign aux_ctrl_o = aux_ff;
	assign pulldown_flags_o = pdf_ff;
	assign halt_release_ctrl_o = hrc_ff;
	assign divider_overflow_release_en_o = hep_ff;
	assign chrono_run_flag_o = cst_ff;
	assign strobe_ptr_ctrl_bit_o = spc_ff;
	assign halt_o = halt_ff;
	assign op_error_o = err_ff;
	assign divider_o = div_ff;
	assign watchdog_counter_o = wdt_ff;
	assign acc_o = acc_ff;
	assign carry_o = cf_ff;

	// Checks on the decode behaviour.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence seq_call_fetch;
		state_ff == nibble_pkg::ST_FETCH && rom_data_i[7:3] == nibble_pkg::PFX_CALL ##1
		state_ff == nibble_pkg::ST_OPER;
	endsequence
	chk_halt_entry: assert property (
		state_ff == nibble_pkg::ST_FETCH && rom_data_i == nibble_pkg::OP_HALT |=> halt_o)
		else $error("halt opcode did not halt");
	chk_halt_hold: assert property (
		halt_o && !release_now |=> halt_o)
		else $error("halt left without release");
	chk_jump_target: assert property (
		state_ff == nibble_pkg::ST_OPER && opc_ff[7:3] == nibble_pkg::PFX_JMP
		|=> pc_ff == $past(jmp_target))
		else $error("jump target wrong");
	chk_branch_skip: assert property (
		state_ff == nibble_pkg::ST_OPER && opc_ff[7:6] == nibble_pkg::PFX_BR && !br_cond
		|=> pc_ff == $past(pc_ff) + 12'h001)
		else $error("failed branch did not skip");
	chk_call_push: assert property (
		seq_call_fetch |=> stk0_ff == $past(pc_ff) + 12'h001 && stk1_ff == $past(stk0_ff))
		else $error("call return address wrong");
	chk_status_clear: assert property (
		state_ff == nibble_pkg::ST_FETCH && rom_data_i == nibble_pkg::OP_OP_READ_CLEAR_HALT_STATUS
		&& scan_flag_set_i == 4'h0 |=> hcs_ff == 4'h0 && acc_ff == $past(hcs_ff))
		else $error("halt cause read-clear wrong");
	chk_out_error: assert property (
		state_ff == nibble_pkg::ST_FETCH && rom_data_i == nibble_pkg::OP_OUT && !spc_ff
		&& sp_ff != nibble_pkg::SP_AUX |=> op_error_o && !sfr_we_o)
		else $error("bad output select not flagged");
	chk_ptr_step: assert property (
		state_ff == nibble_pkg::ST_FETCH && rom_data_i == nibble_pkg::OP_IDPL
		|=> dpl_ff == $past(dpl_ff) + 4'h1 && cf_ff == $past(cf_ff))
		else $error("pointer increment wrong");
	chk_div_clear: assert property (
		div_clr |=> (div_ff & nibble_pkg::DIV_TOP_MASK) == 15'h0000)
		else $error("divider top not cleared");
endmodule

// File: include/nibble_pkg.sv
// Opcodes, field codes and state codes of the nibble controller core.
// Assumes a single 100 MHz clock with the divider stepped every cycle except a top-stage clear cycle.
package nibble_pkg;
	typedef enum logic [1:0] {
		ST_FETCH = 2'b00,
		ST_OPER = 2'b01,
		ST_OP_ROM_NIBBLE_WRITE = 2'b10,
		ST_HALT = 2'b11
	} state_t;
	// One-byte opcodes.
	localparam logic [7:0] OP_HALT = 8'h00;
	localparam logic [7:0] OP_OP_ROM_NIBBLE_WRITE = 8'h02;
	localparam logic [7:0] OP_CSP = 8'h04;
	localparam logic [7:0] OP_CST = 8'h05;
	localparam logic [7:0] OP_RCS = 8'h06;
	localparam logic [7:0] OP_SCS = 8'h07;
	localparam logic [7:0] OP_JMPI = 8'h10;
	localparam logic [7:0] OP_PAGE = 8'h11;
	localparam logic [7:0] OP_RTS = 8'h13;
	localparam logic [7:0] OP_IN = 8'h17;
	localparam logic [7:0] OP_OP_SET_PTR_LOW = 8'h1C;
	localparam logic [7:0] OP_SDPH = 8'h1D;
	localparam logic [7:0] OP_XDPL = 8'h1E;
	localparam logic [7:0] OP_XDPH = 8'h1F;
	localparam logic [7:0] OP_IDPL = 8'h9A;
	localparam logic [7:0] OP_DDPL = 8'h9B;
	localparam logic [7:0] OP_IDPH = 8'h9C;
	localparam logic [7:0] OP_DDPH = 8'h9D;
	localparam logic [7:0] OP_ISP = 8'h9E;
	localparam logic [7:0] OP_DSP = 8'h9F;
	localparam logic [7:0] OP_IPM = 8'hA8;
	localparam logic [7:0] OP_LDA = 8'hA9;
	localparam logic [7:0] OP_LSP = 8'hAA;
	localparam logic [7:0] OP_OP_READ_CLEAR_HALT_STATUS = 8'hAB;
	localparam logic [7:0] OP_STA = 8'hAD;
	localparam logic [7:0] OP_SSP = 8'hAE;
	localparam logic [7:0] OP_IPS = 8'hAF;
	localparam logic [7:0] OP_RCF = 8'hF0;
	localparam logic [7:0] OP_SCF = 8'hF1;
	localparam logic [7:0] OP_PDN = 8'hF?;
	localparam logic [7:0] OP_OP_RESTART_WATCHDOG = 8'hF9;
	localparam logic [7:0] OP_OP_CLEAR_DIVIDER_TOP = 8'hFB;
	localparam logic [7:0] OP_OUT = 8'hFC;
	localparam logic [7:0] OP_LDPL = 8'hFD;
	localparam logic [7:0] OP_LDPH = 8'hFE;
	// Immediate-nibble opcode groups.
	localparam logic [7:0] OP_MVI = 8'h2?;
	localparam logic [7:0] OP_LDI = 8'h3?;
	localparam logic [7:0] OP_MDPL = 8'hB?;
	localparam logic [7:0] OP_MDPH = 8'hC?;
	localparam logic [7:0] OP_SIC = 8'hD?;
	localparam logic [7:0] OP_MSP = 8'hE?;
	localparam logic [5:0] PDN_HI = 6'h3D;
	// Two-byte prefixes.
	localparam logic [4:0] PFX_JMP = 5'h01;
	localparam logic [4:0] PFX_CALL = 5'h14;
	localparam logic [4:0] PFX_ALUI = 5'h12;
	localparam logic [1:0] PFX_BR = 2'h1;
	localparam logic [7:0] OP_BANK = 8'hC8;
	localparam logic [7:0] OP_SPCX = 8'hC9;
	localparam logic [6:0] SEL_HI = 7'h10;
	// Strobe pointer value that reaches the auxiliary control/status.
	localparam logic [3:0] SP_AUX = 4'hD;
	// Divider stages 11 to 15 cleared by the divider-reset opcode.
	localparam logic [14:0] DIV_TOP_MASK = 15'h7C00;
	localparam int WDT_W = 8;
endpackage

// File: test/core_env_model.sv
// Program ROM and nibble data RAM that face the instruction core.
// Assumes the core registers its addresses and reads combinationally.
`timescale 1ns/1ns
module core_env_model (
	// Clock.
	input wire logic ref_clk_i,
	// Program ROM, loaded by the bench before reset is released.
	input wire logic [11:0] rom_addr_i,
	output logic [7:0] rom_data_o,
	// Data RAM.
	input wire logic [5:0] ram_raddr_i,
	input wire logic [5:0] ram_waddr_i,
	input wire logic [3:0] ram_wdata_i,
	input wire logic ram_we_i,
	output logic [3:0] ram_rdata_o
);
	logic [7:0] rom [0:4095];
	logic [3:0] ram [0:63];
	// RAM starts cleared so that no unknown reaches the core.
	initial
	begin
		foreach (ram[i]) ram[i] = 4'h0;
	end
	// Reads follow the address at once, as the core expects.
	assign rom_data_o = rom[rom_addr_i];
	assign ram_rdata_o = ram[ram_raddr_i];
	// A write lands on the rising edge that samples the strobe.
	always @(posedge ref_clk_i)
	begin
		if (ram_we_i)
		begin
			ram[ram_waddr_i] <= ram_wdata_i;
		end
	end
endmodule

// File: test/nibble_mcu_control_branch_decode_tb.sv
// Self-checking bench: a program in the model ROM runs on the core and
// its state is compared whenever the fetch address reaches chosen points.
// Assumes the core fetches its first byte at the first edge after reset.
`timescale 1ns/1ns
module nibble_mcu_control_branch_decode_tb;
	// Clock, reset and pin stimulus.
	logic ref_clk_i, arst_n_i;
	logic [3:0] s_in, m_in, scan_set;
	// Core outputs and model wires.
	logic [7:0] rom_data;
	logic [3:0] ram_rdata, ram_wdata_o, sfr_sel_o, sfr_wdata_o, aux_ctrl_o;
	logic [3:0] halt_release_ctrl_o, acc_o;
	logic [11:0] rom_addr_o;
	logic [5:0] ram_raddr_o, ram_waddr_o;
	logic [1:0] pulldown_flags_o;
	logic ram_we_o, sfr_we_o, divider_overflow_release_en_o, chrono_run_flag_o;
	logic strobe_ptr_ctrl_bit_o, halt_o, op_error_o, carry_o;
	logic [14:0] divider_o;
	logic [nibble_pkg::WDT_W-1:0] watchdog_counter_o;
	int failures = 0, num_checks = 0, n_err = 0, n_sfr = 0, n_we = 0;

	nibble_core uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.rom_data_i(rom_data), .rom_addr_o(rom_addr_o), .ram_rdata_i(ram_rdata),
		.ram_raddr_o(ram_raddr_o), .ram_waddr_o(ram_waddr_o), .ram_wdata_o(ram_wdata_o),
		.ram_we_o(ram_we_o), .s_in_i(s_in), .m_in_i(m_in), .tenth_sec_i(1'b0),
		.scan_flag_set_i(scan_set), .aux_status_i(4'h6), .sfr_rdata_i(4'h9),
		.sfr_we_o(sfr_we_o), .sfr_sel_o(sfr_sel_o), .sfr_wdata_o(sfr_wdata_o),
		.aux_ctrl_o(aux_ctrl_o), .pulldown_flags_o(pulldown_flags_o),
		.halt_release_ctrl_o(halt_release_ctrl_o),
		.divider_overflow_release_en_o(divider_overflow_release_en_o),
		.chrono_run_flag_o(chrono_run_flag_o), .strobe_ptr_ctrl_bit_o(strobe_ptr_ctrl_bit_o),
		.halt_o(halt_o), .op_error_o(op_error_o), .divider_o(divider_o),
		.watchdog_counter_o(watchdog_counter_o), .acc_o(acc_o), .carry_o(carry_o));

	core_env_model env (.ref_clk_i(ref_clk_i), .rom_addr_i(rom_addr_o),
		.rom_data_o(rom_data), .ram_raddr_i(ram_raddr_o), .ram_waddr_i(ram_waddr_o),
		.ram_wdata_i(ram_wdata_o), .ram_we_i(ram_we_o), .ram_rdata_o(ram_rdata));

	// Free-running 100 MHz clock.
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// One-cycle strobes are counted where they have settled.
	always @(negedge ref_clk_i)
	begin
		if (op_error_o === 1'b1) n_err++;
		if (sfr_we_o === 1'b1) n_sfr++;
		if (ram_we_o === 1'b1) n_we++;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
		begin
			$display("Testbench passed");
		end
		else
		begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask

	// Picks one observed quantity, widened to a common width.
	function automatic logic [11:0] sig(input int s);
		case (s)
			0: return {8'h00, acc_o};
			1: return {6'h00, ram_raddr_o};
			2: return {8'h00, sfr_sel_o};
			3: return {8'h00, aux_ctrl_o};
			4: return {10'h000, pulldown_flags_o};
			5: return {11'h000, divider_overflow_release_en_o};
			6: return {11'h000, strobe_ptr_ctrl_bit_o};
			7: return {8'h00, halt_release_ctrl_o};
			8: return {7'h00, divider_o[14:10]};
			9: return 12'(watchdog_counter_o);
			10: return {11'h000, chrono_run_flag_o};
			11: return 12'(n_err);
			12: return 12'(n_sfr);
			13: return {8'h00, sfr_wdata_o};
			15: return {11'h000, carry_o};
			default: return 12'(n_we);
		endcase
	endfunction

	// Waits, bounded, until the fetch address is a, then compares.
	task automatic at(input logic [11:0] a, input int s, input logic [11:0] e);
		int n;
		n = 0;
		while (rom_addr_o !== a && n < 64)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n == 64) chk(rom_addr_o, a);
		// Lets the strobe counters of this same edge settle first.
		#1;
		chk(sig(s), e);
	endtask

	// Copies a run of program bytes into the model ROM.
	task automatic put(input logic [11:0] a, input logic [7:0] b[$]);
		foreach (b[i]) env.rom[a + 12'(i)] = b[i];
	endtask

	// Hang guard, far beyond the length of the program.
	initial
	begin
		#100000;
		failures++;
		$display("[FAIL] %0t: run timed out", $time);
		end_of_test();
	end

	// Main sequence: load program, reset, follow the program's progress.
	initial
	begin
		arst_n_i = 1'b0;
		s_in = 4'h3;
		m_in = 4'hC;
		scan_set = 4'h0;
		foreach (env.rom[i]) env.rom[i] = 8'h00;
		put(12'h000, '{8'h3A, 8'h1C, 8'hC1, 8'hAD, 8'h35, 8'hA9, 8'hFE, 8'hFD,
			8'h9A, 8'h9D, 8'h1E, 8'h1F, 8'h1E, 8'h9B, 8'h9C, 8'h27});
		put(12'h010, '{8'hA9, 8'hE3, 8'h9E, 8'h9F, 8'h9F, 8'hAA, 8'h3D, 8'hAE,
			8'hAB, 8'hAB, 8'h07, 8'h06, 8'hF5, 8'hF6, 8'hAF, 8'hA8});
		put(12'h020, '{8'h3E, 8'hFC, 8'h17, 8'hE3, 8'hFC, 8'hC9, 8'h21, 8'h3B,
			8'hFC, 8'h17, 8'hC9, 8'h20, 8'h3D, 8'hAE, 8'h3E, 8'h02});
		put(12'h030, '{8'hFF, 8'hC2, 8'h21, 8'h11, 8'h20, 8'h38, 8'h10});
		put(12'h0E7, '{8'hA5});
		put(12'h180, '{8'h08, 8'h50});
		put(12'h050, '{8'h30, 8'h40, 8'h60});
		put(12'h060, '{8'h31, 8'h40, 8'h70, 8'h48, 8'h68, 8'h00, 8'h00, 8'h00, 8'h50, 8'h70});
		put(12'h070, '{8'hF0, 8'h70, 8'h80, 8'h60, 8'h78, 8'h00, 8'h00, 8'h00,
			8'hF1, 8'h60, 8'h90, 8'h78, 8'h80, 8'h70, 8'h88});
		put(12'h088, '{8'hA0, 8'hA0, 8'hC8, 8'h21});
		put(12'h0A0, '{8'hA0, 8'hB0, 8'h13});
		put(12'h0B0, '{8'h13});
		put(12'h88C, '{8'hD2, 8'h00, 8'h3F, 8'hFB, 8'hF9, 8'h05, 8'h1D, 8'hB5});
		repeat (16) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		@(negedge ref_clk_i);
		scan_set = 4'h5;
		@(negedge ref_clk_i);
		scan_set = 4'h0;
		at(12'h006, 0, 12'h00A);
		at(12'h006, 1, 12'h01A);
		at(12'h007, 0, 12'h001);
		at(12'h008, 0, 12'h00A);
		at(12'h00A, 1, 12'h00B);
		at(12'h00B, 1, 12'h000);
		at(12'h00D, 1, 12'h00B);
		at(12'h00F, 1, 12'h01A);
		at(12'h011, 0, 12'h007);
		at(12'h013, 2, 12'h004);
		at(12'h015, 2, 12'h002);
		at(12'h016, 0, 12'h002);
		at(12'h018, 2, 12'h00D);
		at(12'h019, 0, 12'h005);
		at(12'h01A, 0, 12'h000);
		at(12'h01B, 5, 12'h001);
		at(12'h01C, 5, 12'h000);
		at(12'h01D, 4, 12'h001);
		at(12'h01E, 4, 12'h002);
		at(12'h01F, 0, 12'h003);
		at(12'h020, 0, 12'h00C);
		at(12'h022, 3, 12'h00E);
		at(12'h023, 0, 12'h006);
		at(12'h025, 3, 12'h00E);
		at(12'h025, 11, 12'h001);
		at(12'h027, 6, 12'h001);
		at(12'h029, 12, 12'h001);
		at(12'h029, 13, 12'h00B);
		at(12'h02A, 0, 12'h009);
		at(12'h02C, 6, 12'h000);
		at(12'h031, 3, 12'h00A);
		at(12'h180, 0, 12'h008);
		at(12'h180, 14, 12'h004);
		at(12'h050, 0, 12'h008);
		at(12'h060, 0, 12'h000);
		at(12'h063, 0, 12'h001);
		at(12'h068, 0, 12'h001);
		at(12'h070, 0, 12'h001);
		at(12'h073, 0, 12'h001);
		at(12'h078, 0, 12'h001);
		at(12'h079, 15, 12'h001);
		at(12'h07B, 0, 12'h001);
		at(12'h07D, 0, 12'h001);
		at(12'h088, 0, 12'h001);
		at(12'h0A0, 0, 12'h001);
		at(12'h0B0, 0, 12'h001);
		at(12'h0A2, 0, 12'h001);
		at(12'h08A, 0, 12'h001);
		at(12'h88C, 0, 12'h001);
		at(12'h88D, 7, 12'h002);
		repeat (4) @(negedge ref_clk_i);
		chk(halt_o, 12'h001);
		s_in = 4'h0;
		m_in = 4'h0;
		repeat (600) @(negedge ref_clk_i);
		m_in = 4'hF;
		repeat (600) @(negedge ref_clk_i);
		chk(halt_o, 12'h001);
		s_in = 4'h1;
		repeat (3) @(negedge ref_clk_i);
		chk(halt_o, 12'h000);
		at(12'h890, 8, 12'h000);
		at(12'h891, 9, 12'h000);
		at(12'h892, 10, 12'h001);
		at(12'h893, 1, 12'h03A);
		at(12'h894, 1, 12'h035);
		end_of_test();
	end
endmodule
